// >>> rtl/tmc_counter_core.sv
// 16-bit free-running timer counter core with byte register port
//
// Operation
// R1 - sixteen-bit up-counter advances per prescaler tick, read as high and low byte
// R2 - internal tick is cpu clock divided by 2, 4 or 8 per source field
// R3 - writing either low byte view reloads the counter with fffc
// R4 - reset loads fffc; fffc is the only value ever reloaded
// R5 - main and alternate views show the same count
// R6 - high byte read first; that read latches the current low byte
// R7 - latched low byte stays frozen over repeated high reads until low read
// R8 - after a completed pair, a lone low read returns the live low byte
// R9 - overflow flag sets when the counter wraps ffff to 0000
// R10 - interrupt requested while flag, enable set and cpu mask clear; stays pending
// R11 - flag clears after status read with flag set, then main low access
// R12 - alternate low byte accesses never touch the overflow flag
// R13 - wait mode changes nothing; timer keeps running
// R14 - halt stops counting; interrupt wake resumes, reset wake restarts at fffc
// R15 - source field all ones selects the external clock pin
// R16 - edge select bit picks which external pin transition counts
// R17 - external counting is synchronised to the cpu clock
// R18 - external clock leaves four cpu clock edges between active edges
// R19 - an unbonded timer pin reads as constant high
// R20 - separate instances share nothing and count in step after reset
// R21 - overflow in the same cycle as the clear step keeps the flag set
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module tmc_counter_core #(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input  wire logic                            SYS_CLK_IN,
  input  wire logic                            RESET_N_IN,
  input  wire logic                            CLK_EN_IN,
  input  wire logic [tmc_pkg::TMC_ADDR_W-1:0]  ADDR_IN,
  input  wire logic [tmc_pkg::TMC_DATA_W-1:0]  WDATA_IN,
  input  wire logic                            WR_IN,
  input  wire logic                            RD_IN,
  input  wire logic                            CPU_IRQ_MASK_IN,
  input  wire logic                            HALT_IN,
  input  wire logic                            EXT_CLOCK_PIN_IN,
  output logic      [tmc_pkg::TMC_DATA_W-1:0]  RDATA_OUT,
  output logic                                 IRQ_OUT,
  output logic      [tmc_pkg::TMC_CNT_W-1:0]   COUNT_OUT
);
  import tmc_pkg::*;

  tmc_core_state_s st;
  tmc_core_state_s next_st;
  logic            tick;
  logic            ext_pin;
  logic            write_low;
  logic            main_low_access;
  logic            wrap;

  // a missing pin must look idle high rather than float
  assign ext_pin = EXT_PIN_BONDED ? EXT_CLOCK_PIN_IN : 1'b1; // see R19

  // wait mode is not an input at all: only halt gates the tick
  tmc_tick_gen u_tick (
    .clk_in     (SYS_CLK_IN),
    .rst_n_in   (RESET_N_IN),
    .ce_in      (CLK_EN_IN),
    .run_in     (~HALT_IN),            // see R13, R14
    .restart_in (write_low),
    .source_in  (st.tick_source_select),
    .edge_in    (st.ext_edge_select),
    .ext_pin_in (ext_pin),             // see R17
    .tick_out   (tick)
  );

  always_comb begin
    next_st         = st;
    write_low       = WR_IN & ((ADDR_IN == TMC_OFS_MAIN_LOW) | (ADDR_IN == TMC_OFS_ALT_LOW)); // see R3
    main_low_access = (WR_IN | RD_IN) & (ADDR_IN == TMC_OFS_MAIN_LOW); // see R12
    wrap            = tick & ~write_low & (st.count == TMC_COUNT_TOP); // see R9

    // counter: reload beats counting in the same cycle
    if (write_low) begin
      next_st.count = TMC_COUNT_RELOAD; // see R3
    end else if (tick) begin
      next_st.count = st.count + TMC_COUNT_ONE; // see R1
    end

    // control writes
    if (WR_IN) begin
      case (ADDR_IN)
        TMC_OFS_CONTROL_ONE: begin
          next_st.irq_enable = WDATA_IN[TMC_BIT_IRQ_ENABLE];
        end
        TMC_OFS_CONTROL_TWO: begin
          next_st.tick_source_select = WDATA_IN[TMC_BIT_SRC_HI:TMC_BIT_SRC_LO]; // see R2, R15
          next_st.ext_edge_select    = WDATA_IN[TMC_BIT_EDGE_SELECT]; // see R16
        end
        default: begin
        end
      endcase
    end

    // reads: data valid in the following cycle only
    next_st.rdata = TMC_BYTE_ZERO;
    if (RD_IN) begin
      case (ADDR_IN)
        TMC_OFS_CONTROL_ONE: begin
          next_st.rdata[TMC_BIT_IRQ_ENABLE] = st.irq_enable;
        end
        TMC_OFS_CONTROL_TWO: begin
          next_st.rdata[TMC_BIT_SRC_HI:TMC_BIT_SRC_LO] = st.tick_source_select;
          next_st.rdata[TMC_BIT_EDGE_SELECT]           = st.ext_edge_select;
        end
        TMC_OFS_STATUS: begin
          next_st.rdata[TMC_BIT_OVF_FLAG] = st.overflow_flag;
          // first step of the clear needs the flag seen set
          if (st.overflow_flag) begin
            next_st.clear_armed = 1'b1; // see R11
          end
        end
        TMC_OFS_MAIN_HIGH, TMC_OFS_ALT_HIGH: begin
          next_st.rdata = st.count[TMC_CNT_W-1:TMC_DATA_W]; // see R5
          // repeated high reads must not refresh the buffered low byte
          if (!st.latched) begin
            next_st.low_latch = st.count[TMC_DATA_W-1:0]; // see R6
            next_st.latched   = 1'b1; // see R7
          end
        end
        TMC_OFS_MAIN_LOW, TMC_OFS_ALT_LOW: begin
          if (st.latched) begin
            next_st.rdata   = st.low_latch; // see R6
            next_st.latched = 1'b0;
          end else begin
            next_st.rdata = st.count[TMC_DATA_W-1:0]; // see R8
          end
        end
        default: begin
          next_st.rdata = TMC_BYTE_ZERO;
        end
      endcase
    end

    // second clear step; a wrap in the same cycle wins
    if (main_low_access && st.clear_armed) begin
      next_st.overflow_flag = 1'b0; // see R11
      next_st.clear_armed   = 1'b0;
    end
    if (wrap) begin
      next_st.overflow_flag = 1'b1; // see R9, R21
    end

    // request held until enable and cpu mask allow it
    next_st.irq = next_st.overflow_flag & next_st.irq_enable & ~CPU_IRQ_MASK_IN; // see R10
  end

  // every instance resets identically, so twins count in step
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st <= '{count: TMC_COUNT_RELOAD, // see R4, R14, R20
              irq_enable: 1'b0,
              tick_source_select: TMC_SRC_RESET,
              ext_edge_select: 1'b0,
              low_latch: TMC_BYTE_ZERO,
              latched: 1'b0,
              clear_armed: 1'b0,
              overflow_flag: 1'b0,
              rdata: TMC_BYTE_ZERO,
              irq: 1'b0};
    end else if (CLK_EN_IN) begin
      st <= next_st;
    end
  end

  assign RDATA_OUT = st.rdata;
  assign IRQ_OUT   = st.irq;
  assign COUNT_OUT = st.count;

endmodule
`default_nettype wire

// >>> rtl/tmc_pkg.sv
// shared constants and state types of the 16-bit timer counter core
`default_nettype none
package tmc_pkg;

  localparam int TMC_ADDR_W = 3;
  localparam int TMC_DATA_W = 8;
  localparam int TMC_CNT_W  = 16;
  localparam int TMC_PRE_W  = 3;

  // register indexes on the plain register port
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_CONTROL_ONE = 3'h0;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_CONTROL_TWO = 3'h1;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_STATUS      = 3'h2;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_MAIN_HIGH   = 3'h3;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_MAIN_LOW    = 3'h4;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_ALT_HIGH    = 3'h5;
  localparam logic [TMC_ADDR_W-1:0] TMC_OFS_ALT_LOW     = 3'h6;

  // field positions
  localparam int TMC_BIT_IRQ_ENABLE  = 5;
  localparam int TMC_BIT_SRC_HI      = 3;
  localparam int TMC_BIT_SRC_LO      = 2;
  localparam int TMC_BIT_EDGE_SELECT = 0;
  localparam int TMC_BIT_OVF_FLAG    = 5;

  // tick source codes
  localparam logic [1:0] TMC_SRC_DIV4 = 2'h0;
  localparam logic [1:0] TMC_SRC_DIV2 = 2'h1;
  localparam logic [1:0] TMC_SRC_DIV8 = 2'h2;
  localparam logic [1:0] TMC_SRC_EXT  = 2'h3;

  // prescaler terminal masks
  localparam logic [TMC_PRE_W-1:0] TMC_MASK_DIV2 = 3'h1;
  localparam logic [TMC_PRE_W-1:0] TMC_MASK_DIV4 = 3'h3;
  localparam logic [TMC_PRE_W-1:0] TMC_MASK_DIV8 = 3'h7;

  // reset and reload values
  localparam logic [TMC_CNT_W-1:0]  TMC_COUNT_RELOAD = 16'hfffc;
  localparam logic [TMC_CNT_W-1:0]  TMC_COUNT_TOP    = 16'hffff;
  localparam logic [TMC_CNT_W-1:0]  TMC_COUNT_ONE    = 16'h0001;
  localparam logic [TMC_DATA_W-1:0] TMC_BYTE_ZERO    = 8'h00;
  localparam logic [TMC_PRE_W-1:0]  TMC_PRE_ZERO     = 3'h0;
  localparam logic [TMC_PRE_W-1:0]  TMC_PRE_ONE      = 3'h1;
  localparam logic [1:0]            TMC_SRC_RESET    = 2'h0;

  typedef struct packed {
    logic [TMC_PRE_W-1:0] presc;
    logic                 sync_a;
    logic                 sync_b;
    logic                 prev;
  } tmc_tick_state_s;

  typedef struct packed {
    logic [TMC_CNT_W-1:0]  count;
    logic                  irq_enable;
    logic [1:0]            tick_source_select;
    logic                  ext_edge_select;
    logic [TMC_DATA_W-1:0] low_latch;
    logic                  latched;
    logic                  clear_armed;
    logic                  overflow_flag;
    logic [TMC_DATA_W-1:0] rdata;
    logic                  irq;
  } tmc_core_state_s;

endpackage
`default_nettype wire

// >>> rtl/tmc_tick_gen.sv
// prescaler and external clock edge detector producing counter ticks
`timescale 1ns/10ps
`default_nettype none
module tmc_tick_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       run_in,
  input  wire logic       restart_in,
  input  wire logic [1:0] source_in,
  input  wire logic       edge_in,
  input  wire logic       ext_pin_in,
  output logic            tick_out
);
  import tmc_pkg::*;

  tmc_tick_state_s st;
  tmc_tick_state_s next_st;
  logic            rise;
  logic            fall;
  logic            ext_edge;

  always_comb begin
    next_st        = st;
    next_st.sync_a = ext_pin_in;
    next_st.sync_b = st.sync_a;
    next_st.prev   = st.sync_b;
    rise           = st.sync_b & ~st.prev;
    fall           = ~st.sync_b & st.prev;
    ext_edge       = edge_in ? rise : fall; // see R16
    // restart so that counting begins from a known phase after a reload
    if (restart_in) begin
      next_st.presc = TMC_PRE_ZERO;
    end else if (run_in) begin
      next_st.presc = st.presc + TMC_PRE_ONE;
    end
    case (source_in)
      TMC_SRC_DIV2: tick_out = run_in & ((st.presc & TMC_MASK_DIV2) == TMC_MASK_DIV2); // see R2
      TMC_SRC_DIV4: tick_out = run_in & ((st.presc & TMC_MASK_DIV4) == TMC_MASK_DIV4); // see R2
      TMC_SRC_DIV8: tick_out = run_in & ((st.presc & TMC_MASK_DIV8) == TMC_MASK_DIV8); // see R2
      TMC_SRC_EXT:  tick_out = run_in & ext_edge; // see R15
      default:      tick_out = 1'b0;
    endcase
  end

  // pin is outside our clock domain: two flops before the edge detector
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '{presc: TMC_PRE_ZERO, sync_a: 1'b1, sync_b: 1'b1, prev: 1'b1};
    end else if (ce_in) begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// >>> test/tmc_counter_core_props.sv
// port assertions for the timer counter core
`timescale 1ns/10ps
`default_nettype none
module tmc_counter_core_props import tmc_pkg::*; (
  input wire logic                  SYS_CLK_IN,
  input wire logic                  RESET_N_IN,
  input wire logic                  CLK_EN_IN,
  input wire logic [TMC_ADDR_W-1:0] ADDR_IN,
  input wire logic                  WR_IN,
  input wire logic                  RD_IN,
  input wire logic                  CPU_IRQ_MASK_IN,
  input wire logic                  HALT_IN,
  input wire logic [TMC_DATA_W-1:0] RDATA_OUT,
  input wire logic                  IRQ_OUT,
  input wire logic [TMC_CNT_W-1:0]  COUNT_OUT
);
  wire       acc = CLK_EN_IN && (RD_IN || WR_IN);
  wire       clr = acc && (ADDR_IN == 3'h4 || ADDR_IN == 3'h0);
  wire       hrd = CLK_EN_IN && RD_IN && (ADDR_IN == 3'h3 || ADDR_IN == 3'h5);
  wire [7:0] hi  = COUNT_OUT[15:8];
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  low_reload_a: assert property (acc && WR_IN && (ADDR_IN == 3'h4 || ADDR_IN == 3'h6) |=> COUNT_OUT == 16'hfffc)
    else $error("low byte write did not reload the count");
  count_step_a: assert property ($changed(COUNT_OUT) |-> COUNT_OUT == $past(COUNT_OUT) + 16'h1 || COUNT_OUT == 16'hfffc)
    else $error("count moved other than by one or reload");
  halt_hold_a: assert property (HALT_IN [*3] ##0 !WR_IN |=> $stable(COUNT_OUT))
    else $error("count moved during halt");
  irq_mask_a: assert property (IRQ_OUT && $past(CLK_EN_IN) |-> !$past(CPU_IRQ_MASK_IN))
    else $error("interrupt raised while masked");
  alt_keep_a: assert property (IRQ_OUT && !CPU_IRQ_MASK_IN && acc && ADDR_IN == 3'h6 |=> IRQ_OUT)
    else $error("alternate low access dropped the interrupt");
  irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(CPU_IRQ_MASK_IN) || $past(clr))
    else $error("interrupt dropped without cause");
  rdata_idle_a: assert property ($past(CLK_EN_IN) && !$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside the answer cycle");
  high_byte_a: assert property (hrd |=> RDATA_OUT == $past(hi))
    else $error("high byte read returned wrong value");
  cover property ($fell(IRQ_OUT));
  cover property (COUNT_OUT == 16'h0000);
  cover property (HALT_IN [*3]);
endmodule
bind tmc_counter_core tmc_counter_core_props i_tmc_counter_core_props (.SYS_CLK_IN, .RESET_N_IN, .CLK_EN_IN,
  .ADDR_IN, .WR_IN, .RD_IN, .CPU_IRQ_MASK_IN, .HALT_IN, .RDATA_OUT, .IRQ_OUT, .COUNT_OUT);
`default_nettype wire

// >>> test/tmc_counter_core_tb.sv
// self-checking bench for the timer counter core
`timescale 1ns/10ps
`default_nettype none
module tmc_counter_core_tb;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, msk = 1'b0, hlt = 1'b0, pin = 1'b0;
  logic [2:0]  adr = 3'h0, pre;
  logic [7:0]  wd = 8'h0, rdo, lv, q[$];
  logic [15:0] cnt, mc;
  logic [1:0]  src;
  logic        irq, ov, en, eg, lat, arm, mi, trk, pend = 1'b0;
  int          n_errors = 0, num_checks = 0, seed = 92, n;
  logic [2:0]  rs[9] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h4, 3'h2, 3'h7, 3'h0, 3'h1};
  logic [1:0]  dv[3] = '{2'h1, 2'h0, 2'h2};
  tmc_counter_core i_tmc_counter_core (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(ce), .ADDR_IN(adr),
    .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .CPU_IRQ_MASK_IN(msk), .HALT_IN(hlt), .EXT_CLOCK_PIN_IN(pin),
    .RDATA_OUT(rdo), .IRQ_OUT(irq), .COUNT_OUT(cnt));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // expectation taken from the model at the strobe edge, before it updates
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    case (a)
      3'h0: q.push_back({2'h0, en, 5'h0});
      3'h1: q.push_back({4'h0, src, 1'b0, eg});
      3'h2: q.push_back({2'h0, ov, 5'h0});
      3'h3, 3'h5: q.push_back(mc[15:8]);
      3'h4, 3'h6: q.push_back(lat ? lv : mc[7:0]);
      default: q.push_back(8'h0);
    endcase
  endtask
  // reference model; a control two write loses prescaler phase until the next reload
  always @(posedge clk or negedge rst_n) begin : model
    logic [15:0] c;
    logic        o;
    logic        w;
    if (!rst_n) begin
      {mc, pre, ov, en, eg, src, lat, arm, mi, trk, lv} <= {16'hfffc, 20'h0};
    end else if (ce) begin
      c = mc;
      o = ov;
      w = 1'b0;
      if (wr && (adr == 3'h4 || adr == 3'h6)) begin
        c = 16'hfffc;
        pre <= 3'h0;
        trk <= src != 2'h3;
      end else if (!hlt && src != 2'h3) begin
        pre <= pre + 3'h1;
        if (pre == (src == 2'h1 ? 3'h1 : src == 2'h2 ? 3'h7 : 3'h3)) begin
          pre <= 3'h0;
          c = mc + 16'h1;
          w = mc == 16'hffff;
        end
      end
      if ((wr || rd) && adr == 3'h4 && arm) o = 1'b0;
      o = o | w;
      if (rd && adr == 3'h2 && ov) arm <= 1'b1;
      if ((wr || rd) && adr == 3'h4) arm <= 1'b0;
      if (rd && (adr == 3'h3 || adr == 3'h5) && !lat) lv <= mc[7:0];
      if (rd && (adr == 3'h3 || adr == 3'h5)) lat <= 1'b1;
      if (rd && (adr == 3'h4 || adr == 3'h6)) lat <= 1'b0;
      if (wr && adr == 3'h0) en <= wd[5];
      if (wr && adr == 3'h1) {src, eg} <= {wd[3:2], wd[0]};
      if (wr && adr == 3'h1) trk <= 1'b0;
      mi <= o & (wr && adr == 3'h0 ? wd[5] : en) & ~msk;
      mc <= c;
      ov <= o;
    end
  end
  always @(posedge clk) begin
    if (pend) chk("read data", 16'(q.pop_front()), 16'(rdo));
    if (trk && rst_n) chk("count", mc, cnt);
    if (trk && rst_n) chk("irq", 16'(mi), 16'(irq));
    pend <= rd & ce;
  end
  initial begin
    repeat (4000) @(posedge clk); // run needs under a thousand cycles
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(3'h4, 8'h0);
    foreach (dv[i]) begin
      wr_reg(3'h1, {4'h0, dv[i], 2'h0});
      wr_reg(3'h0, 8'($random(seed)) | 8'h20);
      wr_reg(3'h4, 8'($random(seed)));
      wr_reg(3'h2, 8'hff);
      wr_reg(3'h3, 8'($random(seed)));
      wr_reg(3'h7, 8'hff);
      repeat (40) @(posedge clk);
      msk <= 1'b1;
      repeat (5) @(posedge clk);
      msk <= 1'b0;
      foreach (rs[j]) rd_reg(rs[j]);
      $display("divider %0d test done", i);
    end
    hlt <= 1'b1;
    repeat (20) @(posedge clk);
    hlt <= 1'b0;
    ce <= 1'b0;
    repeat (9) @(posedge clk);
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    hlt <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("reset count", 16'hfffc, cnt);
    hlt <= 1'b0;
    $display("halt and reset test done");
    for (int k = 0; k < 2; k++) begin
      wr_reg(3'h1, 8'h0c | 8'(k));
      wr_reg(3'h4, 8'h0);
      n = 0;
      repeat (5) begin
        repeat (6) @(posedge clk);
        pin <= ~pin;
        n += int'(~pin == k[0]);
      end
      repeat (8) @(posedge clk);
      #1 chk("ext count", 16'hfffc + 16'(n), cnt);
      $display("external edge %0d test done", k);
    end
    finish_test();
  end
endmodule
`default_nettype wire
